/* File: counter_array_control_mode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module counter_array_control_mode_tb;
   import counter_array_pkg::*;

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   typedef struct packed { logic [2:0] sel; logic [15:0] delta; } row_t;
   logic        sys_clk              = 1'b0;
   logic        rstn                 = 1'b0;
   logic [7:0]  sfr_addr             = 8'h00;
   logic        sfr_wr               = 1'b0;
   logic        sfr_rd               = 1'b0;
   logic [7:0]  sfr_wdata            = 8'h00;
   logic [7:0]  sfr_rdata;
   logic [7:0]  bit_addr             = 8'h00;
   logic        bit_wr               = 1'b0;
   logic        bit_rd               = 1'b0;
   logic        bit_wdata            = 1'b0;
   logic        bit_rdata;
   logic [5:0]  match_capture_event  = 6'h00;
   logic [5:0]  match_irq_enable     = 6'h00;
   logic        cpu_idle             = 1'b0;
   logic        timer0_overflow      = 1'b0;
   logic        external_count_input = 1'b1;
   logic        ext_clk              = 1'b0;
   logic [15:0] counter_value;
   logic        counter_irq;
   logic        watchdog_mode;
   logic        watchdog_reset_req;
   int          error_cnt            = 0;
   int          checks               = 0;
   int          cyc                  = 0;
   logic [15:0] rd;
   logic        bv;
   logic [15:0] d;
   logic        seen;
   row_t        rows [8] = '{'{3'b000, 16'h4}, '{3'b001, 16'hC}, '{3'b010, 16'h8}, '{3'b011, 16'h6},
                             '{3'b100, 16'h30}, '{3'b101, 16'h3}, '{3'b110, 16'h0}, '{3'b111, 16'h0}};

   counter_array_ctrl u_counter_array_ctrl (
      .sys_clk(sys_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
      .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
      .match_capture_event(match_capture_event), .match_irq_enable(match_irq_enable),
      .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
      .external_count_input(external_count_input), .ext_clk(ext_clk),
      .counter_value(counter_value), .counter_irq(counter_irq), .watchdog_mode(watchdog_mode),
      .watchdog_reset_req(watchdog_reset_req));

   always #5 sys_clk = ~sys_clk;

   // Periods all divide the 48-cycle window, so tick counts come out exact
   always @(negedge sys_clk) begin
      cyc                  <= cyc + 1;
      timer0_overflow      <= (cyc % 6 == 0);
      ext_clk              <= ~ext_clk;
      external_count_input <= cyc[2];
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic complete_run();
      if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_val({15'h0, got}, {15'h0, exp});
   endtask

   task automatic do_reset();
      rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      // Idle edge so back-to-back writes never retoggle the strobe in one step
      @(negedge sys_clk);
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [15:0] v);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      @(negedge sys_clk);
      v = {8'h00, sfr_rdata};
   endtask

   task automatic bit_write(input logic [7:0] a, input logic v);
      bit_addr = a;
      bit_wdata = v;
      bit_wr = 1'b1;
      @(negedge sys_clk);
      bit_wr = 1'b0;
   endtask

   task automatic bit_read(input logic [7:0] a, output logic v);
      bit_addr = a;
      bit_rd = 1'b1;
      @(negedge sys_clk);
      bit_rd = 1'b0;
      @(negedge sys_clk);
      v = bit_rdata;
   endtask

   task automatic measure(output logic [15:0] dl);
      logic [15:0] a;
      repeat (20) @(negedge sys_clk);
      a = counter_value;
      repeat (48) @(negedge sys_clk);
      dl = counter_value - a;
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      error_cnt++;
      complete_run();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      check_bit(watchdog_mode, 1'b1);
      sfr_read(MODE_ADDR, rd);
      check_val(rd, 16'h40);
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'h00);
      sfr_read(8'h10, rd);
      check_val(rd, 16'h00);
      sfr_write(MODE_ADDR, 8'hFF);
      sfr_read(MODE_ADDR, rd);
      check_val(rd, 16'h40);
      sfr_write(MODE_ADDR, 8'h00);
      sfr_write(MODE_ADDR, 8'h9F);
      sfr_read(MODE_ADDR, rd);
      check_val(rd, 16'h8F);
      sfr_write(CTRL_ADDR, 8'h40);
      foreach (rows[i]) begin
         sfr_write(MODE_ADDR, {4'h0, rows[i].sel, 1'b0});
         measure(d);
         check_val(d, rows[i].delta);
      end
      // Match flags, interrupt sharing and set-over-clear
      match_irq_enable = 6'h04;
      sfr_write(MODE_ADDR, 8'h08);
      match_capture_event = 6'h04;
      @(negedge sys_clk);
      match_capture_event = 6'h02;
      check_bit(counter_irq, 1'b1);
      @(negedge sys_clk);
      match_capture_event = 6'h00;
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'h46);
      bit_write(8'hDA, 1'b0);
      @(negedge sys_clk);
      check_bit(counter_irq, 1'b0);
      match_capture_event = 6'h08;
      bit_write(8'hDB, 1'b0);
      match_capture_event = 6'h00;
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'h4A);
      bit_read(8'hDB, bv);
      check_bit(bv, 1'b1);
      bit_read(8'hDA, bv);
      check_bit(bv, 1'b0);
      bit_read(8'hDE, bv);
      check_bit(bv, 1'b1);
      bit_read(8'h10, bv);
      check_bit(bv, 1'b0);
      // Idle suspension
      cpu_idle = 1'b1;
      for (int k = 0; k < 2; k++) begin
         sfr_write(MODE_ADDR, k ? 8'h08 : 8'h88);
         measure(d);
         check_val(d, k ? 16'h30 : 16'h0);
      end
      cpu_idle = 1'b0;
      // Full wrap of the counter is the long part of the run
      sfr_write(MODE_ADDR, 8'h09);
      for (int k = 0; k < 70000 && counter_value !== 16'hFFFF; k++) @(negedge sys_clk);
      check_bit(counter_irq, 1'b0);
      repeat (3) @(negedge sys_clk);
      check_bit(counter_irq, 1'b1);
      sfr_write(MODE_ADDR, 8'h08);
      @(negedge sys_clk);
      check_bit(counter_irq, 1'b0);
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'hCA);
      bit_write(8'hDF, 1'b0);
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'h4A);
      // Watchdog forced run, lock and software kick
      do_reset();
      measure(d);
      check_bit(d != 16'h0, 1'b1);
      sfr_read(CTRL_ADDR, rd);
      check_val(rd, 16'h00);
      sfr_write(MODE_ADDR, 8'h00);
      sfr_write(MODE_ADDR, 8'h20);
      sfr_write(MODE_ADDR, 8'h00);
      sfr_read(MODE_ADDR, rd);
      check_val(rd, 16'h60);
      check_bit(watchdog_mode, 1'b1);
      seen = 1'b0;
      bit_write(8'hDD, 1'b1);
      repeat (3) begin
         seen |= (watchdog_reset_req === 1'b1);
         @(negedge sys_clk);
      end
      check_bit(seen, 1'b1);
      do_reset();
      sfr_write(MODE_ADDR, 8'h00);
      check_bit(watchdog_mode, 1'b0);
      bit_write(8'hDD, 1'b1);
      check_bit(watchdog_reset_req, 1'b0);
      complete_run();
   end
endmodule // counter_array_control_mode_tb
`default_nettype wire

/* File: counter_array_ctrl.sv */
// Function
// - Counter wrap sets overflow flag; software clears
// - Overflow enable gates overflow interrupt request
// - Run bit stops or starts counting
// - Match/capture flags set by hardware, sticky
// - Enabled match flags raise shared interrupt
// - Idle suspend halts array during CPU idle
// - Watchdog enable resets to one
// - Lock blocks watchdog disable until reset
// - Timebase select picks counter tick source
// - External input falling edges counted
// - External clock divided eight, synchronised
// - Watchdog on freezes other mode bits
// - Mode bit four reads zero
// - Control register is bit addressable
// - Watchdog forces counter run; run reads stored
// - Writing one to flag five resets while watchdog on
`timescale 1ns/1ps
`default_nettype none
module counter_array_ctrl (
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   // Byte register access
   input  wire logic [7:0]                  sfr_addr,
   input  wire logic                        sfr_wr,
   input  wire logic                        sfr_rd,
   input  wire logic [7:0]                  sfr_wdata,
   output logic      [7:0]                  sfr_rdata,
   // Bit register access
   input  wire logic [7:0]                  bit_addr,
   input  wire logic                        bit_wr,
   input  wire logic                        bit_rd,
   input  wire logic                        bit_wdata,
   output logic                             bit_rdata,
   // Module events and system
   input  wire logic [counter_array_pkg::NUM_MODULES-1:0] match_capture_event,
   input  wire logic [counter_array_pkg::NUM_MODULES-1:0] match_irq_enable,
   input  wire logic                        cpu_idle,
   input  wire logic                        timer0_overflow,
   input  wire logic                        external_count_input,
   input  wire logic                        ext_clk,
   // Status out
   output logic      [15:0]                 counter_value,
   output logic                             counter_irq,
   output logic                             watchdog_mode,
   output logic                             watchdog_reset_req
);
   import counter_array_pkg::*;

   // ****************************************
   // State
   // ****************************************
   logic                   ovf_q, run_q;
   logic [NUM_MODULES-1:0] mflag_q;
   logic                   idle_q, wd_on_q, lock_q, ovf_ie_q;
   timebase_t              tbs_q;
   logic [15:0]            cnt_q;
   logic                   tick;

   function automatic logic [7:0] bit_onehot(input logic [2:0] idx);
      bit_onehot = 8'h01 << idx;
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   wire       ctrl_byte_wr = sfr_wr & (sfr_addr == CTRL_ADDR);
   wire       mode_wr      = sfr_wr & (sfr_addr == MODE_ADDR);
   wire       ctrl_bit_hit = (bit_addr[7:3] == CTRL_ADDR[7:3]);
   wire [7:0] bit_sel      = bit_onehot(bit_addr[2:0]);
   // Per-bit write mask and value covering both access paths
   wire [7:0] ctrl_wmask   = ctrl_byte_wr ? 8'hFF : ((bit_wr & ctrl_bit_hit) ? bit_sel : 8'h00);
   wire [7:0] ctrl_wval    = ctrl_byte_wr ? sfr_wdata : {8{bit_wdata}};
   wire [7:0] ctrl_view    = {ovf_q, run_q, mflag_q};
   wire [7:0] mode_view    = {idle_q, wd_on_q, lock_q, 1'b0, tbs_q, ovf_ie_q};

   wire suspend  = idle_q & cpu_idle;
   wire run_eff  = (run_q | wd_on_q) & ~suspend;
   wire inc      = tick & run_eff;
   wire wrap     = inc & (cnt_q == COUNT_MAX);

   // Software view merged first, hardware sets OR'd on top
   wire [7:0] ctrl_sw  = (ctrl_view & ~ctrl_wmask) | (ctrl_wval & ctrl_wmask);
   wire       ovf_d    = ctrl_sw[CTRL_OVF_BIT] | wrap;
   wire [NUM_MODULES-1:0] mflag_d = ctrl_sw[NUM_MODULES-1:0] | match_capture_event;
   wire       wd_kick  = wd_on_q & ctrl_wmask[CTRL_KICK_BIT] & ctrl_wval[CTRL_KICK_BIT];

   // Mode writes: only enable may move while watchdog is on
   wire wd_on_req = sfr_wdata[MODE_WDON_BIT] | (~wd_on_q & sfr_wdata[MODE_LOCK_BIT]);
   wire wd_on_d   = (mode_wr & ~lock_q) ? wd_on_req : wd_on_q;
   wire mode_open = mode_wr & ~wd_on_q;
   wire irq_d     = (ovf_d & ovf_ie_q) | |(mflag_d & match_irq_enable);

   // ****************************************
   // Timebase
   // ****************************************
   counter_array_timebase u_timebase (
      .sys_clk              (sys_clk),
      .rstn                 (rstn),
      .timebase_select      (tbs_q),
      .halt                 (suspend),
      .timer0_overflow      (timer0_overflow),
      .external_count_input (external_count_input),
      .ext_clk              (ext_clk),
      .tick                 (tick)
   );

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {ovf_q, run_q, mflag_q} <= CTRL_RESET;
         idle_q   <= MODE_RESET[MODE_IDLE_BIT];
         wd_on_q  <= MODE_RESET[MODE_WDON_BIT];
         lock_q   <= MODE_RESET[MODE_LOCK_BIT];
         tbs_q    <= timebase_t'(MODE_RESET[MODE_TBS_HI:MODE_TBS_LO]);
         ovf_ie_q <= MODE_RESET[MODE_OVIE_BIT];
         cnt_q  <= 16'h0000;
      end else begin
         ovf_q  <= ovf_d;
         run_q  <= ctrl_sw[CTRL_RUN_BIT];
         mflag_q <= mflag_d;
         wd_on_q <= wd_on_d;
         if (mode_open) begin
            idle_q   <= sfr_wdata[MODE_IDLE_BIT];
            lock_q   <= sfr_wdata[MODE_LOCK_BIT];
            tbs_q    <= timebase_t'(sfr_wdata[MODE_TBS_HI:MODE_TBS_LO]);
            ovf_ie_q <= sfr_wdata[MODE_OVIE_BIT];
         end
         if (inc) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   // Outputs straight from flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata          <= 8'h00_00;
         bit_rdata          <= 1'b0;
         counter_irq        <= 1'b0;
         watchdog_reset_req <= 1'b0;
      end else begin
         if (sfr_rd) begin
            sfr_rdata <= (sfr_addr == CTRL_ADDR) ? ctrl_view :
                         (sfr_addr == MODE_ADDR) ? mode_view : 8'h00_00;
         end
         if (bit_rd) begin
            bit_rdata <= ctrl_bit_hit & |(ctrl_view & bit_sel);
         end
         counter_irq        <= irq_d;
         watchdog_reset_req <= wd_kick;
      end
   end

   assign counter_value = cnt_q;
   assign watchdog_mode = wd_on_q;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_kick;
      wd_on_q && ctrl_wmask[CTRL_KICK_BIT] && ctrl_wval[CTRL_KICK_BIT];
   endsequence

   property p_ovf_set;
      @(posedge sys_clk) disable iff (!rstn) wrap |=> ovf_q;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

   property p_ovf_hold;
      @(posedge sys_clk) disable iff (!rstn) ovf_q && !ctrl_wmask[CTRL_OVF_BIT] |=> ovf_q;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared by hardware");

   property p_ovf_irq;
      @(posedge sys_clk) disable iff (!rstn) ovf_q && ovf_ie_q && !ctrl_wmask[CTRL_OVF_BIT] |=> counter_irq;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

   property p_stopped;
      @(posedge sys_clk) disable iff (!rstn) !run_q && !wd_on_q |=> $stable(cnt_q);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

   property p_mflag_set;
      @(posedge sys_clk) disable iff (!rstn)
         match_capture_event != '0 |=> (mflag_q & $past(match_capture_event)) == $past(match_capture_event);
   endproperty
   a_mflag_set: assert property (p_mflag_set) else $error("match flag lost");

   property p_idle;
      @(posedge sys_clk) disable iff (!rstn) idle_q && cpu_idle |=> $stable(cnt_q);
   endproperty
   a_idle: assert property (p_idle) else $error("counter moved in idle suspend");

   property p_lock;
      @(posedge sys_clk) disable iff (!rstn) lock_q && wd_on_q |=> wd_on_q && lock_q;
   endproperty
   a_lock: assert property (p_lock) else $error("locked watchdog disabled");

   property p_frozen;
      @(posedge sys_clk) disable iff (!rstn) wd_on_q |=> $stable({idle_q, lock_q, tbs_q, ovf_ie_q});
   endproperty
   a_frozen: assert property (p_frozen) else $error("mode bits changed with watchdog on");

   property p_bit4;
      @(posedge sys_clk) disable iff (!rstn) sfr_rd && sfr_addr == MODE_ADDR |=> !sfr_rdata[MODE_ZERO_BIT];
   endproperty
   a_bit4: assert property (p_bit4) else $error("mode bit four read nonzero");

   property p_wd_kick;
      @(posedge sys_clk) disable iff (!rstn) s_kick |=> watchdog_reset_req ##1 !watchdog_reset_req || $past(wd_kick);
   endproperty
   a_wd_kick: assert property (p_wd_kick) else $error("watchdog reset not raised");

endmodule // counter_array_ctrl
`default_nettype wire

/* File: counter_array_pkg.sv */
`default_nettype none
package counter_array_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [7:0] CTRL_ADDR = 8'hD8;
   localparam logic [7:0] MODE_ADDR = 8'hD9;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int CTRL_OVF_BIT  = 7;
   localparam int CTRL_RUN_BIT  = 6;
   localparam int CTRL_KICK_BIT = 5;
   localparam int NUM_MODULES   = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ****************************************
   // Mode register fields
   // ****************************************
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_WDON_BIT = 6;
   localparam int MODE_LOCK_BIT = 5;
   localparam int MODE_ZERO_BIT = 4;
   localparam int MODE_TBS_HI   = 3;
   localparam int MODE_TBS_LO   = 1;
   localparam int MODE_OVIE_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h40;

   // ****************************************
   // Timebase divisors and counter limits
   // ****************************************
   localparam logic [3:0]  SYS_DIV_SLOW = 4'hC;
   localparam logic [3:0]  SYS_DIV_FAST = 4'h4;
   localparam logic [2:0]  EXT_DIV_MAX  = 3'h7;
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

   typedef enum logic [2:0] {
      TB_SYS_DIV12 = 3'b000,
      TB_SYS_DIV4  = 3'b001,
      TB_TIMER0    = 3'b010,
      TB_EXT_FALL  = 3'b011,
      TB_SYS       = 3'b100,
      TB_EXT_DIV8  = 3'b101,
      TB_RSVD_A    = 3'b110,
      TB_RSVD_B    = 3'b111
   } timebase_t;

endpackage
`default_nettype wire

/* File: counter_array_timebase.sv */
`timescale 1ns/1ps
`default_nettype none
module counter_array_timebase (
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rstn,
   // Control
   input  wire counter_array_pkg::timebase_t timebase_select,
   input  wire logic                         halt,
   // Tick sources
   input  wire logic                         timer0_overflow,
   input  wire logic                         external_count_input,
   input  wire logic                         ext_clk,
   // Tick out
   output logic                              tick
);
   import counter_array_pkg::*;

   logic       cin_s1_q, cin_s2_q, cin_s3_q;
   logic       ecl_s1_q, ecl_s2_q, ecl_s3_q;
   logic [3:0] pre_q, pre_d;
   logic [2:0] ext_div_q, ext_div_d;
   logic       tick_d;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         // Idle high, so release gives no false falling edge
         cin_s1_q <= 1'b1;
         cin_s2_q <= 1'b1;
         cin_s3_q <= 1'b1;
         ecl_s1_q <= 1'b0;
         ecl_s2_q <= 1'b0;
         ecl_s3_q <= 1'b0;
      end else begin
         cin_s1_q <= external_count_input;
         cin_s2_q <= cin_s1_q;
         cin_s3_q <= cin_s2_q;
         ecl_s1_q <= ext_clk;
         ecl_s2_q <= ecl_s1_q;
         ecl_s3_q <= ecl_s2_q;
      end
   end

   // Edges seen only after two stages
   wire cin_fall  = cin_s3_q & ~cin_s2_q;
   wire ecl_rise  = ecl_s2_q & ~ecl_s3_q;
   wire [3:0] pre_lim = (timebase_select == TB_SYS_DIV12) ? SYS_DIV_SLOW : SYS_DIV_FAST;
   wire pre_wrap  = (pre_q >= pre_lim - 4'h1);
   wire ext_wrap  = ecl_rise & (ext_div_q == EXT_DIV_MAX);

   assign pre_d     = halt ? pre_q : (pre_wrap ? 4'h0 : pre_q + 4'h1);
   assign ext_div_d = (halt | ~ecl_rise) ? ext_div_q : ext_div_q + 3'h1;

   always_comb begin
      unique case (timebase_select)
         TB_SYS_DIV12: tick_d = pre_wrap;
         TB_SYS_DIV4:  tick_d = pre_wrap;
         TB_TIMER0:    tick_d = timer0_overflow;
         TB_EXT_FALL:  tick_d = cin_fall;
         TB_SYS:       tick_d = 1'b1;
         TB_EXT_DIV8:  tick_d = ext_wrap;
         TB_RSVD_A:    tick_d = 1'b0;
         TB_RSVD_B:    tick_d = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pre_q     <= 4'h0;
         ext_div_q <= 3'h0;
         tick      <= 1'b0;
      end else begin
         pre_q     <= pre_d;
         ext_div_q <= ext_div_d;
         tick      <= tick_d & ~halt;
      end
   end

endmodule // counter_array_timebase
`default_nettype wire
